// ---- ppsc_pkg.sv ----
// Constants for the port power-state and fault controller.
// Assumes a single 20 MHz core clock.
`default_nettype none
package ppsc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // Qualify time, retry interval and discharge time in nanoseconds
  localparam int QUAL_TIME_NS = 2_000;
  localparam int RETRY_TIME_NS = 200_000_000;
  localparam int DISCH_TIME_NS = 100_000;
  // Least times round up to whole cycles
  localparam int QUAL_CYC = (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC = (RETRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISCH_CYC = (DISCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  // Configuration register fields
  localparam int CFG_PIN_IGNORE = 0;
  localparam int CFG_MODE_A = 1;
  localparam int CFG_MODE_B = 2;
  localparam int CFG_EMUL = 3;
  localparam int CFG_PORT_POWER_ENABLE = 4;
  localparam int CFG_ATTACH = 5;
  localparam int CFG_LATCH = 6;
  localparam int CFG_ALERT_MASK = 7;
  // Status register fields
  localparam int ST_ERR = 0;
  localparam int ST_BV = 1;
  localparam int ST_STATE_LO = 2;
  localparam int ST_ATT = 5;
  localparam int ST_POL = 6;
  localparam int ST_SMB = 7;
  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_DETECT = 3'h1,
    ST_DISCH = 3'h3,
    ST_ACTIVE = 3'h2,
    ST_ERROR = 3'h6
  } ppsc_state_e;
endpackage
`default_nettype wire

// ---- ppsc_ctrl.sv ----
// Port power-state sequencer: Sleep, Detect, discharge, Active and Error.
// Assumes pins and analog comparator flags arrive asynchronously; the
// register port is on ref_clk_i.
// Operation
// - Active refused on source lockout, enable off, mode zero, or gate on without attach
// - Each entry to Active starts the host-selected mode
// - From Active, any of six faults enters Error
// - From Detect, only back-drive or over-temperature enters Error
// - From Sleep, only back-drive enters Error
// - In Error all switches open; alert driven unless masked
// - Latching handler rechecks after flag clear or enable toggle
// - Auto-recovery rechecks after one retry interval in Error
// - Clean recheck returns to Active, Detect or Sleep; Active restarts mode
// - Removal in Error rechecks then follows current controls
// - Back-voltage opens switches and sets flag leading to Error
// - Source back-voltage opens port at once; qualifies to Error
// - Core back-voltage opens bypass at once; qualifies to Error
// - Source over-voltage beyond qualify time disables port, enters Error
// - Polarity strap sampled once after reset; later changes ignored
// - Mode zero with enable active disables attach and removal detection
// - SMBus pin-ignore selects bits only; else enable and mode bits combine with pins
// - Fault handler from pin stand-alone, from bit in SMBus
// - Attach gate from bit in SMBus, from pin otherwise
// - Attach gate one needs attach; zero disables detection
// - Detect to Active: bypass off, discharge, then port on
`timescale 1ns/100ps
`default_nettype none
module ppsc_ctrl
  import ppsc_pkg::*;
#(
  parameter int QUAL_CYCLES = ppsc_pkg::QUAL_CYC,
  parameter int RETRY_CYCLES = ppsc_pkg::RETRY_CYC,
  parameter int DISCH_CYCLES = ppsc_pkg::DISCH_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ppsc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ppsc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ppsc_pkg::DATA_W-1:0] rdata_o,
  // Straps and control pins
  input wire logic polarity_strap_i,
  input wire logic smbus_mode_i,
  input wire logic port_power_enable_i,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic emulation_enable_i,
  input wire logic attach_gate_enable_i,
  input wire logic latch_pin_i,
  // Analog condition flags
  input wire logic src_undervolt_i,
  input wire logic src_overvolt_i,
  input wire logic over_temp_i,
  input wire logic over_current_i,
  input wire logic vbus_undervolt_i,
  input wire logic backvolt_src_i,
  input wire logic backvolt_core_i,
  input wire logic discharge_err_i,
  input wire logic attach_det_i,
  input wire logic removal_det_i,
  // Switch controls and status
  output logic port_sw_o,
  output logic bypass_sw_o,
  output logic hs_sw_o,
  output logic discharge_sw_o,
  output logic attach_det_en_o,
  output logic removal_det_en_o,
  output logic mode_restart_o,
  output logic [2:0] active_mode_o,
  output logic smbus_addr_sel_o,
  // Open-drain fault alert
  output logic alert_o,
  output logic alert_oen_o
);
  import ppsc_pkg::*;

  localparam int NSYNC = 17;

  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic pol_s, smb_s, en_pin_s, ma_s, mb_s, em_s, s0_pin_s, latch_pin_s;
  logic uvlo_s, ov_s, ot_s, oc_s, vuv_s, bv_src_s, bv_core_s, dis_err_s;
  logic att_s, rem_s;
  ppsc_state_e state_reg, state_next, settle;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg, polarity_reg, smbus_reg;
  logic [DATA_W-1:0] cfg_reg;
  logic err_flag_reg, bv_flag_reg, attached_reg, en_prev_reg;
  logic [CNT_W-1:0] retry_cnt_reg, disch_cnt_reg;
  logic [CNT_W-1:0] qual_cnt_reg [3];
  logic [2:0] qual_cond, qual_hit;
  logic en_eff, s0_eff, latch_eff, mode_zero, go_active;
  logic [2:0] mode_eff;
  logic err_active, err_detect, err_sleep, err_now;
  logic err_clr, en_toggle, removal_evt, recheck;

  // Two-flop synchronisers on every asynchronous input
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {polarity_strap_i, smbus_mode_i, port_power_enable_i,
                    mode_pin_a_i, mode_pin_b_i, emulation_enable_i,
                    attach_gate_enable_i, latch_pin_i, src_undervolt_i,
                    src_overvolt_i, over_temp_i, over_current_i, vbus_undervolt_i,
                    backvolt_src_i, backvolt_core_i, discharge_err_i,
                    attach_det_i};
      sync2_reg <= sync1_reg;
    end
  end

  // Removal detect is synchronised on its own pair
  logic rem1_reg, rem2_reg;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem1_reg <= 1'b0;
      rem2_reg <= 1'b0;
    end else begin
      rem1_reg <= removal_det_i;
      rem2_reg <= rem1_reg;
    end
  end

  assign {pol_s, smb_s, en_pin_s, ma_s, mb_s, em_s, s0_pin_s, latch_pin_s,
          uvlo_s, ov_s, ot_s, oc_s, vuv_s, bv_src_s, bv_core_s, dis_err_s,
          att_s} = sync2_reg;
  assign rem_s = rem2_reg;

  // Straps are taken once, after the synchronisers have settled
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      polarity_reg <= 1'b1;
      smbus_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        polarity_reg <= pol_s;
        smbus_reg <= smb_s;
      end
    end
  end

  // Effective controls from pins or configuration bits
  always_comb begin
    if (smbus_reg && cfg_reg[CFG_PIN_IGNORE]) begin
      en_eff = cfg_reg[CFG_PORT_POWER_ENABLE];
      mode_eff = {cfg_reg[CFG_EMUL], cfg_reg[CFG_MODE_B], cfg_reg[CFG_MODE_A]};
    end else if (smbus_reg) begin
      en_eff = cfg_reg[CFG_PORT_POWER_ENABLE] | (en_pin_s == polarity_reg);
      mode_eff = {cfg_reg[CFG_EMUL] | em_s, cfg_reg[CFG_MODE_B] | mb_s,
                  cfg_reg[CFG_MODE_A] | ma_s};
    end else begin
      en_eff = (en_pin_s == polarity_reg);
      mode_eff = {em_s, mb_s, ma_s};
    end
    latch_eff = smbus_reg ? cfg_reg[CFG_LATCH] : latch_pin_s;
    s0_eff = smbus_reg ? cfg_reg[CFG_ATTACH] : s0_pin_s;
  end

  assign mode_zero = (mode_eff == 3'h0);
  assign go_active = !uvlo_s && en_eff && !mode_zero
                     && (!s0_eff || (attached_reg && !removal_evt));
  assign settle = go_active ? ST_ACTIVE : (s0_eff ? ST_DETECT : ST_SLEEP);

  // Qualify counters: source back-voltage, core back-voltage, over-voltage
  assign qual_cond[0] = bv_src_s && (state_reg == ST_ACTIVE || state_reg == ST_SLEEP);
  assign qual_cond[1] = bv_core_s && (state_reg == ST_DETECT || state_reg == ST_SLEEP);
  assign qual_cond[2] = ov_s && (state_reg == ST_ACTIVE);

  for (genvar i = 0; i < 3; i++) begin : g_qual
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        qual_cnt_reg[i] <= '0;
      end else if (!qual_cond[i]) begin
        qual_cnt_reg[i] <= '0;
      end else if (qual_cnt_reg[i] != CNT_W'(QUAL_CYCLES)) begin
        qual_cnt_reg[i] <= qual_cnt_reg[i] + CNT_W'(1);
      end
    end
    assign qual_hit[i] = qual_cond[i] && (qual_cnt_reg[i] == CNT_W'(QUAL_CYCLES));
  end

  // Error causes per state
  assign err_active = ot_s || oc_s || vuv_s || dis_err_s
                      || qual_hit[0] || qual_hit[2];
  assign err_detect = qual_hit[1] || ot_s;
  assign err_sleep = qual_hit[0] || qual_hit[1];
  assign err_now = ot_s || oc_s || vuv_s || dis_err_s || ov_s
                   || bv_src_s || bv_core_s;

  assign err_clr = wr_i && smbus_reg && addr_i == ADDR_STAT && wdata_i[ST_ERR];
  assign en_toggle = en_eff != en_prev_reg;
  assign removal_evt = rem_s && removal_det_en_o;
  assign recheck = (latch_eff ? (err_clr || en_toggle)
                    : (retry_cnt_reg == CNT_W'(RETRY_CYCLES)))
                   || removal_evt;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP: begin
        if (!strap_done_reg) state_next = ST_SLEEP;
        else if (err_sleep) state_next = ST_ERROR;
        else state_next = settle;
      end
      ST_DETECT: begin
        if (err_detect) state_next = ST_ERROR;
        else if (settle == ST_ACTIVE) state_next = ST_DISCH;
        else state_next = settle;
      end
      ST_DISCH: begin
        if (err_active) state_next = ST_ERROR;
        else if (!go_active) state_next = settle;
        else if (disch_cnt_reg == CNT_W'(DISCH_CYCLES)) state_next = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (err_active) state_next = ST_ERROR;
        else if (!go_active) state_next = settle;
      end
      ST_ERROR: begin
        if (recheck && !err_now) state_next = settle;
      end
      default: state_next = ST_SLEEP;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) state_reg <= ST_SLEEP;
    else state_reg <= state_next;
  end

  // Retry and discharge timers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      retry_cnt_reg <= '0;
      disch_cnt_reg <= '0;
    end else begin
      if (state_reg != ST_ERROR || recheck) retry_cnt_reg <= '0;
      else retry_cnt_reg <= retry_cnt_reg + CNT_W'(1);
      if (state_reg != ST_DISCH) disch_cnt_reg <= '0;
      else disch_cnt_reg <= disch_cnt_reg + CNT_W'(1);
    end
  end

  // Attach tracking and detection enables
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      attached_reg <= 1'b0;
      attach_det_en_o <= 1'b0;
      removal_det_en_o <= 1'b0;
      en_prev_reg <= 1'b0;
    end else begin
      en_prev_reg <= en_eff;
      if (!s0_eff || state_reg == ST_SLEEP || removal_evt) attached_reg <= 1'b0;
      else if (att_s && attach_det_en_o) attached_reg <= 1'b1;
      attach_det_en_o <= s0_eff && !(mode_zero && en_eff)
                         && state_next == ST_DETECT && !attached_reg;
      removal_det_en_o <= s0_eff && !(mode_zero && en_eff)
                          && attached_reg && state_next != ST_SLEEP;
    end
  end

  // Switch drive follows the next state so Error and open switches coincide
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_sw_o <= 1'b0;
      bypass_sw_o <= 1'b0;
      hs_sw_o <= 1'b0;
      discharge_sw_o <= 1'b0;
      alert_oen_o <= 1'b1;
    end else begin
      port_sw_o <= state_next == ST_ACTIVE && !bv_src_s;
      bypass_sw_o <= state_next == ST_DETECT && !bv_core_s;
      hs_sw_o <= state_next == ST_ACTIVE;
      discharge_sw_o <= state_next == ST_DISCH;
      alert_oen_o <= !(state_next == ST_ERROR && !cfg_reg[CFG_ALERT_MASK]);
    end
  end
  assign alert_o = 1'b0;

  // Mode restart on every entry to Active
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_restart_o <= 1'b0;
      active_mode_o <= 3'h0;
      smbus_addr_sel_o <= 1'b0;
    end else begin
      mode_restart_o <= state_next == ST_ACTIVE && state_reg != ST_ACTIVE;
      if (state_next == ST_ACTIVE && state_reg != ST_ACTIVE) active_mode_o <= mode_eff;
      smbus_addr_sel_o <= smbus_reg && polarity_reg;
    end
  end

  // Registers; writes are ignored outside SMBus mode
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= CFG_RESET;
      err_flag_reg <= 1'b0;
      bv_flag_reg <= 1'b0;
    end else begin
      if (wr_i && smbus_reg && addr_i == ADDR_CFG) cfg_reg <= wdata_i;
      if (state_next == ST_ERROR && state_reg != ST_ERROR) err_flag_reg <= 1'b1;
      else if (err_clr) err_flag_reg <= 1'b0;
      if (|qual_hit[1:0]) bv_flag_reg <= 1'b1;
      else if (wr_i && smbus_reg && addr_i == ADDR_STAT && wdata_i[ST_BV])
        bv_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) rdata_o <= '0;
    else if (rd_i && addr_i == ADDR_CFG) rdata_o <= cfg_reg;
    else if (rd_i && addr_i == ADDR_STAT)
      rdata_o <= {smbus_reg, polarity_reg, attached_reg, state_reg,
                  bv_flag_reg, err_flag_reg};
    else rdata_o <= '0;
  end

  a_port_needs_active: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    port_sw_o |-> state_reg == ST_ACTIVE && go_active || state_reg == ST_ACTIVE)
    else $error("port switch closed outside Active");
  a_active_refused: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_ACTIVE && !go_active |=> state_reg != ST_ACTIVE)
    else $error("Active held while refused");
  a_mode_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_ACTIVE && $past(state_reg) != ST_ACTIVE |-> mode_restart_o)
    else $error("no mode restart on Active entry");
  a_active_to_error: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_ACTIVE && err_active |=> state_reg == ST_ERROR)
    else $error("Active fault missed");
  a_detect_no_error: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_DETECT && !err_detect |=> state_reg != ST_ERROR)
    else $error("Detect entered Error wrongly");
  a_sleep_no_error: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_SLEEP && !err_sleep |=> state_reg != ST_ERROR)
    else $error("Sleep entered Error wrongly");
  a_error_open_sw: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_ERROR |-> !port_sw_o && !bypass_sw_o && !hs_sw_o)
    else $error("switch closed in Error");
  a_latch_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_ERROR && latch_eff && !recheck |=> state_reg == ST_ERROR)
    else $error("latched Error left without re-arm");
  a_retry_wait: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_ERROR && !latch_eff && !removal_evt
    && retry_cnt_reg < CNT_W'(RETRY_CYCLES) |=> state_reg == ST_ERROR)
    else $error("Error left before retry interval");
  a_error_stays: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    state_reg == ST_ERROR && err_now |=> state_reg == ST_ERROR)
    else $error("Error left with fault present");
  a_bv_port_open: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    bv_src_s |=> !port_sw_o)
    else $error("port not opened on back-voltage");
  a_bv_bypass_open: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    bv_core_s |=> !bypass_sw_o)
    else $error("bypass not opened on back-voltage");
  a_disch_first: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(discharge_sw_o) |-> !port_sw_o && !bypass_sw_o)
    else $error("discharge overlaps port or bypass");
endmodule // ppsc_ctrl
`default_nettype wire

// ---- ppsc_host_model.sv ----
// Host-side model: drives the control pins and resolves the fault alert line.
// Assumes one bench process calls its tasks, on the core clock.
`timescale 1ns/100ps
`default_nettype none
module ppsc_host_model (
  // Clock
  input wire logic clk_i,
  // Fault alert from the device
  input wire logic alert_i,
  input wire logic alert_oen_n_i,
  output logic alert_line_o,
  // Control pins, mode as {emulation, b, a}
  output logic port_power_enable_o,
  output logic [2:0] mode_o,
  output logic gate_o,
  output logic latch_o
);
  // Pulled-up line: low only while the device pulls it
  assign alert_line_o = alert_oen_n_i ? 1'b1 : alert_i;
  initial begin
    port_power_enable_o = 1'b0;
    mode_o = 3'h0;
    gate_o = 1'b0;
    latch_o = 1'b0;
  end
  task automatic set_ctrl(input logic en, input logic [2:0] m, input logic g, input logic l);
    @(posedge clk_i);
    port_power_enable_o <= en;
    mode_o <= m;
    gate_o <= g;
    latch_o <= l;
  endtask
  // Re-arms a latched fault by turning the enable off and on again
  task automatic toggle_enable();
    @(posedge clk_i);
    port_power_enable_o <= ~port_power_enable_o;
    repeat (4) @(posedge clk_i);
    port_power_enable_o <= ~port_power_enable_o;
  endtask
endmodule // ppsc_host_model
`default_nettype wire

// ---- port_power_state_control_test.sv ----
// Self-checking bench for the port power-state controller.
// Assumes short timer parameters; the host model drives the control pins.
`timescale 1ns/100ps
`default_nettype none
module port_power_state_control_test;
  import ppsc_pkg::*;
  localparam int QUAL = 4;
  localparam int RETRY = 20;
  localparam int DISCH = 8;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 4'h0;
  logic [DATA_W-1:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pol = 1'b1;
  logic smb = 1'b1;
  // Flags 0-7 analog conditions, 8 attach, 9 removal
  logic [9:0] flg = 10'h000;
  logic [DATA_W-1:0] rdata_o;
  logic port_sw, bypass_sw, hs_sw, disch_sw, att_en, rem_en, restart, addr_sel;
  logic alert, alert_oen_n, alert_line, en_pin, gate_pin, latch_pin;
  logic [2:0] act_mode, mode_pins, mode, s;
  logic [7:0] d;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_restart = 0;
  int n_disch = 0;
  int r;
  int faults[$] = '{2, 3, 4, 5, 7, 1};
  always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (restart === 1'b1) n_restart++;
    if (disch_sw === 1'b1) n_disch++;
  end
  ppsc_ctrl #(.QUAL_CYCLES(QUAL), .RETRY_CYCLES(RETRY), .DISCH_CYCLES(DISCH)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .polarity_strap_i(pol),
    .smbus_mode_i(smb), .port_power_enable_i(en_pin), .mode_pin_a_i(mode_pins[0]),
    .mode_pin_b_i(mode_pins[1]), .emulation_enable_i(mode_pins[2]),
    .attach_gate_enable_i(gate_pin), .latch_pin_i(latch_pin), .src_undervolt_i(flg[0]),
    .src_overvolt_i(flg[1]), .over_temp_i(flg[2]), .over_current_i(flg[3]),
    .vbus_undervolt_i(flg[4]), .backvolt_src_i(flg[5]), .backvolt_core_i(flg[6]),
    .discharge_err_i(flg[7]), .attach_det_i(flg[8]), .removal_det_i(flg[9]),
    .port_sw_o(port_sw), .bypass_sw_o(bypass_sw), .hs_sw_o(hs_sw),
    .discharge_sw_o(disch_sw), .attach_det_en_o(att_en), .removal_det_en_o(rem_en),
    .mode_restart_o(restart), .active_mode_o(act_mode), .smbus_addr_sel_o(addr_sel),
    .alert_o(alert), .alert_oen_o(alert_oen_n));
  ppsc_host_model i_host (
    .clk_i(ref_clk_i), .alert_i(alert), .alert_oen_n_i(alert_oen_n),
    .alert_line_o(alert_line), .port_power_enable_o(en_pin), .mode_o(mode_pins),
    .gate_o(gate_pin), .latch_o(latch_pin));
  // Ends at a falling edge so outputs are settled when looked at
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic set_flag(input int i, input logic v);
    @(posedge ref_clk_i);
    flg[i] <= v;
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata_o;
    s = d[ST_STATE_LO +: 3];
  endtask
  task automatic cfg(input logic ign, input logic g, input logic l);
    reg_wr(ADDR_CFG, 8'(ign) << CFG_PIN_IGNORE | 8'(g) << CFG_ATTACH | 8'(l) << CFG_LATCH);
  endtask
  // Polls the state field under a bounded number of reads
  task automatic wait_state(input string what, input logic [2:0] e, input int lim);
    reg_rd(ADDR_STAT);
    for (int i = 0; i < lim && s !== e; i++) reg_rd(ADDR_STAT);
    check(what, s, e);
  endtask
  task automatic do_reset(input logic p, input logic sm);
    @(posedge ref_clk_i);
    pol <= p;
    smb <= sm;
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    tick(4);
  endtask
  // Reference power state with the source supply present
  function automatic logic [2:0] exp_state(input logic e, input logic [2:0] m, input logic g,
      input logic a);
    if (e && m != 3'h0 && (!g || a)) return ST_ACTIVE;
    if (g) return ST_DETECT;
    return ST_SLEEP;
  endfunction
  task automatic done(input string t);
    $display("test %s finished, %0d mismatches", t, n_mismatch);
  endtask
  task automatic complete_run();
    $display("%0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #(CLK_PERIOD_NS * 40_000);
    n_mismatch++;
    complete_run();
  end
  initial begin
    r = $urandom(32'h3da8a1d3);
    do_reset(1'b1, 1'b1);
    reg_rd(ADDR_CFG);
    check("cfg reset", d, CFG_RESET);
    reg_rd(4'h9);
    check("unmapped read", d, 8'h00);
    reg_rd(ADDR_STAT);
    check("status after reset", d, 8'hc0);
    check("address select", addr_sel, 1'b1);
    done("reset");
    mode = 3'($urandom_range(7, 1));
    cfg(1'b0, 1'b0, 1'b1);
    i_host.set_ctrl(1'b1, mode, 1'b1, 1'b1);
    wait_state("active entry", exp_state(1'b1, mode, 1'b0, 1'b0), 20);
    check("port on", {port_sw, hs_sw, alert_line}, 3'b111);
    check("active mode", act_mode, mode);
    check("restarts", 8'(n_restart), 8'h01);
    for (int k = 0; k < 4; k++) begin
      set_flag(0, k == 0);
      i_host.set_ctrl(k != 1, k == 2 ? 3'h0 : mode, 1'b1, 1'b1);
      cfg(k == 3, k == 2, 1'b1);
      tick(12);
      check("refused", port_sw, 1'b0);
      if (k == 2) check("detection off", {att_en, rem_en}, 2'b00);
      set_flag(0, 1'b0);
      cfg(1'b0, 1'b0, 1'b1);
      i_host.set_ctrl(1'b1, mode, 1'b1, 1'b1);
      wait_state("reentry", ST_ACTIVE, 20);
    end
    done("refusal");
    foreach (faults[j]) begin
      n_restart = 0;
      set_flag(faults[j], 1'b1);
      tick(4);
      if (faults[j] == 5) check("port opens at once", port_sw, 1'b0);
      wait_state("error entry", ST_ERROR, 20);
      check("error outputs", {port_sw, bypass_sw, hs_sw, alert_line}, 4'h0);
      check("flags", d[1:0], {faults[j] == 5, 1'b1});
      set_flag(faults[j], 1'b0);
      tick(12);
      reg_rd(ADDR_STAT);
      check("latched", s, ST_ERROR);
      reg_wr(ADDR_STAT, 8'h03);
      wait_state("rearmed", ST_ACTIVE, 20);
      check("mode restarted", 8'(n_restart), 8'h01);
    end
    for (int k = 1; k < 6; k += 4) begin
      set_flag(k, 1'b1);
      set_flag(k, 1'b0);
      tick(12);
      reg_rd(ADDR_STAT);
      check("short pulse", {s, port_sw}, {ST_ACTIVE, 1'b1});
    end
    done("faults");
    cfg(1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      set_flag(3, 1'b1);
      tick(k == 0 ? 2 : RETRY + 10);
      set_flag(3, k[0]);
      tick(k == 0 ? RETRY / 2 : 0);
      reg_rd(ADDR_STAT);
      check("still in error", s, ST_ERROR);
      set_flag(3, 1'b0);
      wait_state("auto recovery", ST_ACTIVE, RETRY);
    end
    done("retry");
    cfg(1'b0, 1'b1, 1'b1);
    wait_state("detect", exp_state(1'b1, mode, 1'b1, 1'b0), 20);
    check("detect switches", {bypass_sw, att_en, port_sw}, 3'b110);
    set_flag(3, 1'b1);
    tick(12);
    reg_rd(ADDR_STAT);
    check("current ignored in detect", s, ST_DETECT);
    set_flag(3, 1'b0);
    set_flag(6, 1'b1);
    tick(4);
    check("bypass opens at once", bypass_sw, 1'b0);
    wait_state("detect error", ST_ERROR, 20);
    set_flag(6, 1'b0);
    tick(4);
    reg_wr(ADDR_STAT, 8'h03);
    wait_state("rearm to detect", ST_DETECT, 20);
    n_disch = 0;
    set_flag(8, 1'b1);
    wait_state("attach", ST_ACTIVE, 30);
    check("discharged", n_disch >= DISCH, 1'b1);
    check("after attach", {port_sw, bypass_sw, att_en, rem_en}, 4'b1001);
    set_flag(8, 1'b0);
    set_flag(3, 1'b1);
    wait_state("attached error", ST_ERROR, 20);
    set_flag(3, 1'b0);
    tick(4);
    n_restart = 0;
    set_flag(9, 1'b1);
    set_flag(9, 1'b0);
    wait_state("removal recheck", ST_DETECT, 20);
    check("no restart on removal", 8'(n_restart), 8'h00);
    cfg(1'b0, 1'b0, 1'b1);
    i_host.set_ctrl(1'b0, mode, 1'b1, 1'b1);
    wait_state("sleep", exp_state(1'b0, mode, 1'b0, 1'b0), 20);
    set_flag(2, 1'b1);
    tick(12);
    reg_rd(ADDR_STAT);
    check("heat ignored in sleep", s, ST_SLEEP);
    set_flag(2, 1'b0);
    set_flag(5, 1'b1);
    wait_state("sleep back-drive", ST_ERROR, 20);
    set_flag(5, 1'b0);
    done("detect and sleep");
    do_reset(1'b0, 1'b0);
    reg_wr(ADDR_CFG, 8'hff);
    reg_rd(ADDR_CFG);
    check("write ignored", d, CFG_RESET);
    check("address select off", addr_sel, 1'b0);
    @(posedge ref_clk_i);
    pol <= 1'b1;
    i_host.set_ctrl(1'b0, mode, 1'b0, 1'b1);
    wait_state("active low enable", ST_ACTIVE, 20);
    set_flag(3, 1'b1);
    wait_state("error", ST_ERROR, 20);
    set_flag(3, 1'b0);
    tick(12);
    reg_rd(ADDR_STAT);
    check("latch pin", s, ST_ERROR);
    i_host.toggle_enable();
    wait_state("toggle rearm", ST_ACTIVE, 20);
    check("strap kept", d[ST_POL], 1'b0);
    done("stand-alone");
    complete_run();
  end
endmodule // port_power_state_control_test
`default_nettype wire
